// ===== core/dfs_pkg.sv
// constants and carriers for the dual flash command sequencer
// assumes one 25 MHz core clock and bus inputs synchronous to it
package dfs_pkg;
	// ************************************************************
	// geometry
	// ************************************************************
	localparam int PRI_SECTORS = 8;
	localparam int SEC_SECTORS = 4;
	localparam int ALL_SECTORS = PRI_SECTORS + SEC_SECTORS;
	localparam int SECT_ADDR_W = 12;
	localparam int ADDR_W      = 16;

	// ************************************************************
	// command codes and addresses
	// ************************************************************
	localparam logic [11:0] ADR_CODE1 = 12'h555;
	localparam logic [11:0] ADR_CODE2 = 12'hAAA;
	localparam logic [7:0] CMD_UNLK1   = 8'hAA;
	localparam logic [7:0] CMD_UNLK2   = 8'h55;
	localparam logic [7:0] CMD_IDENT   = 8'h90;
	localparam logic [7:0] CMD_PROG    = 8'hA0;
	localparam logic [7:0] CMD_ERASE   = 8'h80;
	localparam logic [7:0] CMD_SECTOR  = 8'h30;
	localparam logic [7:0] CMD_BULK    = 8'h10;
	localparam logic [7:0] CMD_SUSPEND = 8'hB0;
	localparam logic [7:0] CMD_RESET   = 8'hF0;
	localparam logic [7:0] CMD_BYPASS  = 8'h20;
	localparam logic [7:0] CMD_BYP_END = 8'h00;
	localparam logic [7:0] DATA_PROT   = 8'h01;
	localparam logic [7:0] DATA_UNPROT = 8'h00;
	localparam logic [7:0] ERASED_BYTE = 8'hFF;

	// ************************************************************
	// timing
	// ************************************************************
	localparam int CLK_MHZ        = 25;
	localparam int ERASE_WIN_US   = 80;
	localparam int ERASE_WIN_CYC  = ERASE_WIN_US * CLK_MHZ;
	localparam int CMD_GAP_US     = 80;
	localparam int CMD_GAP_CYC    = CMD_GAP_US * CLK_MHZ;
	localparam int PROG_CYC       = 16;
	localparam int ERASE_CYC      = 64;

	// ************************************************************
	// decoder states
	// ************************************************************
	typedef enum logic [11:0] {
		ST_READ   = 12'b0000_0000_0001,
		ST_U1     = 12'b0000_0000_0010,
		ST_U2     = 12'b0000_0000_0100,
		ST_ID     = 12'b0000_0000_1000,
		ST_PDATA  = 12'b0000_0001_0000,
		ST_E3     = 12'b0000_0010_0000,
		ST_E4     = 12'b0000_0100_0000,
		ST_E5     = 12'b0000_1000_0000,
		ST_EWIN   = 12'b0001_0000_0000,
		ST_BYP    = 12'b0010_0000_0000,
		ST_BPDATA = 12'b0100_0000_0000,
		ST_BEXIT  = 12'b1000_0000_0000
	} dfs_state_e;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [7:0]        data;
		logic [ALL_SECTORS-1:0] sel;
	} dfs_wr_s;
endpackage : dfs_pkg

// ===== core/dfs_sequencer.sv
// dual flash command sequencer: decodes unlock-coded writes into array operations
// assumes bus strobes synchronous to CORE_CLK and sector selects from an outside decoder
//
// Operation
// (R1) primary eight sectors, secondary four sectors
// (R2) each sector protected individually from changes
// (R3) ready/busy low during program or erase
// (R4) only full command sequences change array
// (R5) host confirms program completion by polling
// (R6) read mode returns stored byte directly
// (R7) AA/55/90 then read gives identifier
// (R8) after 90 prefix, read gives protection
// (R9) AA/55/A0 then data programs byte
// (R10) address on strobe fall, data rise
// (R11) erase prefix then 30 sector or 10 bulk
// (R12) B0 suspends only a running sector erase
// (R13) 30 resumes only a suspended erase
// (R14) F0 returns to read mode; code ignores it in ST_BYP, programs it as data in ST_BPDATA
// (R15) AA/55/20 enters bypass, A0 programs
// (R16) bypass 90 then 00 exits bypass
// (R17) only A11-A0 compared for commands
// (R18) host gives even don't-care addresses
// (R19) active select picks array and sector
// (R20) host never commands its own code array
// (R21) bad byte or timeout returns read; code stays in bypass on a bad byte in ST_BYP or ST_BEXIT
// (R22) reset initialises into read mode
// (R23) program to protected sector is ignored
// (R24) timeouts are parameterised clock counters
`timescale 1ns/1ps
`default_nettype none
module dfs_sequencer
	import dfs_pkg::*;
#(
	parameter int GAP_CYC   = CMD_GAP_CYC,
	parameter int WIN_CYC   = ERASE_WIN_CYC,
	parameter int PRG_CYC   = PROG_CYC,
	parameter int ERS_CYC   = ERASE_CYC,
	parameter logic [7:0] IDENT_CODE = 8'h5A  // arbitrary value
) (
	// clock and reset
	input  wire logic                   CORE_CLK,
	input  wire logic                   RST_B,
	// mcu bus
	input  wire logic [ADDR_W-1:0]      ADDR,
	input  wire logic [7:0]             WDATA,
	input  wire logic                   WR_STROBE_B,
	input  wire logic                   RD_STROBE_B,
	input  wire logic [PRI_SECTORS-1:0] PRIMARY_SECTOR_SELECT,
	input  wire logic [SEC_SECTORS-1:0] SECONDARY_SECTOR_SELECT,
	output logic [7:0]                  RDATA,
	// status and protection
	input  wire logic [ALL_SECTORS-1:0] SECTOR_PROTECT,
	output logic                        READY_BUSY_OUTPUT,
	output logic                        ERROR_FLAG_BIT
);
	// ************************************************************
	// storage and state
	// ************************************************************
	localparam int MEM_W = $clog2(ALL_SECTORS) + SECT_ADDR_W;
	// a sector erase writes every byte of its sector once, then settles for ERS_CYC more,
	// so busy spans about one sector size plus ERS_CYC for each sector erased
	localparam int ERS_SPAN = ERS_CYC + (1 << SECT_ADDR_W);
	logic [7:0]             mem_r [ALL_SECTORS * (1 << SECT_ADDR_W)];
	dfs_state_e             st_r;
	dfs_wr_s                wr_r;
	logic                   wr_b_d_r;
	logic                   rd_b_d_r;
	logic                   wr_done;
	logic [31:0]            gap_r;
	logic [31:0]            win_r;
	logic [31:0]            busy_cnt_r;
	logic                   prog_busy_r;
	logic                   erase_busy_r;
	logic                   suspend_r;
	logic                   id_mode_r;
	logic [ALL_SECTORS-1:0] erase_set_r;
	logic [MEM_W-1:0]       prog_idx_r;
	logic [7:0]             prog_data_r;
	logic [3:0]             erase_sect_r;
	logic [ALL_SECTORS-1:0] sel_now;
	logic                   even_adr;

	function automatic logic [3:0] sel_index(input logic [ALL_SECTORS-1:0] s);
		logic [3:0] idx;
		idx = 4'h0;
		for (int i = ALL_SECTORS - 1; i >= 0; i--) begin
			if (s[i]) begin
				idx = 4'(i);
			end
		end
		return idx;
	endfunction : sel_index

	function automatic logic cmd_at(input dfs_wr_s w, input logic [7:0] d, input logic [11:0] a);
		return (w.data == d) && (w.addr[SECT_ADDR_W-1:0] == a); // R17
	endfunction : cmd_at

	// R1 R19 primary selects sit in the low bits, secondary above
	assign sel_now  = {SECONDARY_SECTOR_SELECT, PRIMARY_SECTOR_SELECT};
	assign wr_done  = WR_STROBE_B && !wr_b_d_r;
	assign even_adr = !wr_r.addr[0];

	// ************************************************************
	// bus capture
	// ************************************************************
	always_ff @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			wr_b_d_r <= 1'b1;
			rd_b_d_r <= 1'b1;
			wr_r     <= '0;
		end else begin
			wr_b_d_r <= WR_STROBE_B;
			rd_b_d_r <= RD_STROBE_B;
			if (!WR_STROBE_B && wr_b_d_r) begin
				wr_r.addr <= ADDR;        // R10
				wr_r.sel  <= sel_now;
			end
			if (wr_done) begin
				wr_r.data <= WDATA;       // R10
			end
		end
	end

	// completed write as seen by the decoder, data taken at the rising edge
	dfs_wr_s cw;
	always_comb begin
		cw      = wr_r;
		cw.data = WDATA;
	end

	// ************************************************************
	// command decoder
	// ************************************************************
	logic start_prog;
	logic start_erase;
	logic bulk_req;
	logic [3:0] cw_sect;
	assign cw_sect = sel_index(cw.sel);

	always_ff @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			st_r        <= ST_READ;        // R22
			id_mode_r   <= 1'b0;
			gap_r       <= '0;
			win_r       <= '0;
			erase_set_r <= '0;
			start_prog  <= 1'b0;
			start_erase <= 1'b0;
			bulk_req    <= 1'b0;
			prog_idx_r  <= '0;
			prog_data_r <= '0;
		end else begin
			start_prog  <= 1'b0;
			start_erase <= 1'b0;
			// R21 R24 inter-byte timeout aborts a partial sequence
			if (st_r inside {ST_U1, ST_U2, ST_PDATA, ST_E3, ST_E4, ST_E5}) begin
				gap_r <= gap_r + 32'd1;
				if (gap_r >= 32'(GAP_CYC)) begin
					st_r <= ST_READ;
				end
			end
			// R11 R24 erase window closes and erase starts
			if (st_r == ST_EWIN) begin
				win_r <= win_r + 32'd1;
				if (win_r >= 32'(WIN_CYC)) begin
					start_erase <= 1'b1;
					st_r        <= ST_READ;
				end
			end
			if (wr_done && |cw.sel) begin  // R19
				gap_r <= '0;
				if (cw.data == CMD_RESET && st_r != ST_BYP && st_r != ST_BPDATA) begin
					st_r      <= ST_READ;     // R14
					id_mode_r <= 1'b0;
				end else if (cw.data == CMD_SUSPEND && !cw.addr[0]) begin
					st_r <= st_r;             // handled by the array engine
				end else if (cw.data == CMD_SECTOR && suspend_r && !cw.addr[0]) begin
					st_r <= st_r;             // resume, handled by the array engine
				end else begin
					unique case (st_r)
						ST_READ: begin
							// R4 a lone write is only ever a command byte
							st_r <= cmd_at(cw, CMD_UNLK1, ADR_CODE1) ? ST_U1 : ST_READ;
						end
						ST_U1: st_r <= cmd_at(cw, CMD_UNLK2, ADR_CODE2) ? ST_U2 : ST_READ; // R21
						ST_U2: begin
							if (cmd_at(cw, CMD_IDENT, ADR_CODE1)) begin
								st_r      <= ST_READ;     // R7 R8
								id_mode_r <= 1'b1;
							end else if (cmd_at(cw, CMD_PROG, ADR_CODE1)) begin
								st_r <= ST_PDATA;         // R9
							end else if (cmd_at(cw, CMD_ERASE, ADR_CODE1)) begin
								st_r <= ST_E3;            // R11
							end else if (cmd_at(cw, CMD_BYPASS, ADR_CODE1)) begin
								st_r <= ST_BYP;           // R15
							end else begin
								st_r <= ST_READ;          // R21
							end
						end
						ST_PDATA, ST_BPDATA: begin
							prog_idx_r  <= MEM_W'({cw_sect, cw.addr[SECT_ADDR_W-1:0]});
							prog_data_r <= cw.data;
							start_prog  <= 1'b1;          // R9 R15
							st_r        <= (st_r == ST_BPDATA) ? ST_BYP : ST_READ;
						end
						ST_E3: st_r <= cmd_at(cw, CMD_UNLK1, ADR_CODE2) ? ST_E4 : ST_READ;
						ST_E4: st_r <= cmd_at(cw, CMD_UNLK2, ADR_CODE2) ? ST_E5 : ST_READ;
						ST_E5: begin
							erase_set_r <= '0;
							if (cw.data == CMD_SECTOR) begin
								erase_set_r <= cw.sel;    // R11 R19
								win_r       <= '0;
								bulk_req    <= 1'b0;
								st_r        <= ST_EWIN;
							end else if (cmd_at(cw, CMD_BULK, ADR_CODE1)) begin
								bulk_req    <= 1'b1;
								start_erase <= 1'b1;
								st_r        <= ST_READ;
							end else begin
								st_r <= ST_READ;
							end
						end
						ST_EWIN: begin
							if (cw.data == CMD_SECTOR) begin
								erase_set_r <= erase_set_r | cw.sel; // R11
								win_r       <= '0;
							end else begin
								st_r <= ST_READ;          // R21
							end
						end
						ST_BYP: begin
							if (cw.data == CMD_PROG) begin
								st_r <= ST_BPDATA;        // R15
							end else if (cw.data == CMD_IDENT && even_adr) begin
								st_r <= ST_BEXIT;         // R16
							end
						end
						ST_BEXIT: st_r <= (cw.data == CMD_BYP_END) ? ST_READ : ST_BYP; // R16
					endcase
				end
			end
		end
	end

	// ************************************************************
	// array engine: program, erase, suspend
	// ************************************************************
	logic [ALL_SECTORS-1:0] erase_todo_r;
	logic                   prog_ok;
	// protection is looked at once, as the program starts; a later change does not stop it
	assign prog_ok = !SECTOR_PROTECT[prog_idx_r[MEM_W-1:SECT_ADDR_W]]; // R2 R23
	always_ff @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			prog_busy_r  <= 1'b0;
			erase_busy_r <= 1'b0;
			suspend_r    <= 1'b0;
			busy_cnt_r   <= '0;
			erase_todo_r <= '0;
			erase_sect_r <= '0;
		end else begin
			if (start_prog) begin
				prog_busy_r <= prog_ok; // R23
				busy_cnt_r  <= '0;
			end else if (prog_busy_r) begin
				busy_cnt_r <= busy_cnt_r + 32'd1;
				if (busy_cnt_r >= 32'(PRG_CYC)) begin
					prog_busy_r <= 1'b0;
				end
			end
			if (start_erase) begin
				erase_todo_r <= (bulk_req ? {ALL_SECTORS{1'b1}} : erase_set_r) & ~SECTOR_PROTECT; // R2
				erase_busy_r <= 1'b1;
				busy_cnt_r   <= '0;
			end else if (erase_busy_r && !suspend_r) begin
				if (erase_todo_r == '0) begin
					erase_busy_r <= 1'b0;
				end else begin
					erase_sect_r <= sel_index(erase_todo_r);
					busy_cnt_r   <= busy_cnt_r + 32'd1;
					if (busy_cnt_r >= 32'(ERS_SPAN)) begin
						erase_todo_r[sel_index(erase_todo_r)] <= 1'b0;
						busy_cnt_r <= '0;
					end
				end
			end
			if (wr_done && |cw.sel && !cw.addr[0]) begin
				if (cw.data == CMD_SUSPEND && erase_busy_r && !bulk_req) begin
					suspend_r <= 1'b1;    // R12
				end else if (cw.data == CMD_SECTOR && suspend_r) begin
					suspend_r <= 1'b0;    // R13
				end
			end
		end
	end

	// ************************************************************
	// array storage
	// ************************************************************
	logic prog_write;
	logic erase_write;
	assign prog_write = prog_busy_r && busy_cnt_r == 32'(PRG_CYC);
	// one byte per cycle while the count walks from 1 up to the sector size
	assign erase_write = erase_busy_r && !suspend_r && busy_cnt_r != '0
		&& busy_cnt_r <= 32'(1 << SECT_ADDR_W);
	always_ff @(posedge CORE_CLK) begin
		if (prog_write) begin
			mem_r[prog_idx_r] <= mem_r[prog_idx_r] & prog_data_r; // R4
		end else if (erase_write) begin
			mem_r[MEM_W'({erase_sect_r, SECT_ADDR_W'(busy_cnt_r - 32'd1)})] <= ERASED_BYTE;
		end
	end

	// ************************************************************
	// read path and outputs
	// ************************************************************
	logic [3:0] rd_sect;
	assign rd_sect = sel_index(sel_now);
	always_ff @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			RDATA             <= 8'h00;
			READY_BUSY_OUTPUT <= 1'b1;
			ERROR_FLAG_BIT    <= 1'b0;
		end else begin
			// the start pulse is qualified by protection: a refused program must not
			// flash busy for a cycle, or a host polling the pin sees a phantom operation
			READY_BUSY_OUTPUT <= !(prog_busy_r || erase_busy_r || (start_prog && prog_ok) || start_erase); // R3
			ERROR_FLAG_BIT    <= 1'b0;
			if (!RD_STROBE_B && |sel_now) begin
				if (id_mode_r && ADDR[1:0] == 2'b10) begin
					RDATA <= SECTOR_PROTECT[rd_sect] ? DATA_PROT : DATA_UNPROT; // R8
				end else if (id_mode_r && ADDR[6] == 1'b0 && ADDR[1:0] == 2'b01
					&& |PRIMARY_SECTOR_SELECT) begin
					RDATA <= IDENT_CODE;  // R7
				end else begin
					RDATA <= mem_r[MEM_W'({rd_sect, ADDR[SECT_ADDR_W-1:0]})]; // R6
				end
			end
		end
	end
endmodule : dfs_sequencer
`default_nettype wire

// ===== testbench/dfs_sequencer_chk.sv
// checker for the sequencer ports
// assumes binding onto dfs_sequencer
`timescale 1ns/1ps
`default_nettype none
module dfs_sequencer_chk
	import dfs_pkg::*;
#(
	parameter int WIN_CYC = ERASE_WIN_CYC
) (
	input wire logic                   CORE_CLK,
	input wire logic                   RST_B,
	input wire logic [ADDR_W-1:0]      ADDR,
	input wire logic [7:0]             WDATA,
	input wire logic                   WR_STROBE_B,
	input wire logic                   RD_STROBE_B,
	input wire logic [PRI_SECTORS-1:0] PRIMARY_SECTOR_SELECT,
	input wire logic [SEC_SECTORS-1:0] SECONDARY_SECTOR_SELECT,
	input wire logic [7:0]             RDATA,
	input wire logic [ALL_SECTORS-1:0] SECTOR_PROTECT,
	input wire logic                   READY_BUSY_OUTPUT,
	input wire logic                   ERROR_FLAG_BIT
);
	int unsigned since_wr_r;
	int unsigned busy_r;
	logic        nosel;
	assign nosel = !(|PRIMARY_SECTOR_SELECT) && !(|SECONDARY_SECTOR_SELECT);
	// saturate so a long idle run cannot wrap
	always_ff @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) since_wr_r <= 0;
		else if (!WR_STROBE_B) since_wr_r <= 0;
		else if (since_wr_r < 100000) since_wr_r <= since_wr_r + 1;
	end
	always_ff @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) busy_r <= 0;
		else if (READY_BUSY_OUTPUT) busy_r <= 0;
		else busy_r <= busy_r + 1;
	end
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!RST_B);
	property p_ready_out_of_reset;
		$rose(RST_B) |-> READY_BUSY_OUTPUT && !ERROR_FLAG_BIT;
	endproperty
	a_ready_out_of_reset: assert property (p_ready_out_of_reset) else $error("not ready after reset");
	property p_err_low;
		!ERROR_FLAG_BIT;
	endproperty
	a_err_low: assert property (p_err_low) else $error("error flag raised");
	property p_busy_min;
		$fell(READY_BUSY_OUTPUT) |-> !READY_BUSY_OUTPUT [*8];
	endproperty
	a_busy_min: assert property (p_busy_min) else $error("busy too short");
	property p_busy_max;
		busy_r < 60000;
	endproperty
	a_busy_max: assert property (p_busy_max) else $error("busy never ends");
	property p_busy_cause;
		$fell(READY_BUSY_OUTPUT) |-> since_wr_r <= 4 || since_wr_r >= WIN_CYC;
	endproperty
	a_busy_cause: assert property (p_busy_cause) else $error("busy without a command");
	property p_rdata_hold;
		RD_STROBE_B |=> $stable(RDATA);
	endproperty
	a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
	property p_rdata_nosel;
		nosel |=> $stable(RDATA);
	endproperty
	a_rdata_nosel: assert property (p_rdata_nosel) else $error("unselected read");
	property p_wr_nosel;
		$rose(WR_STROBE_B) && $past(nosel) && READY_BUSY_OUTPUT |-> READY_BUSY_OUTPUT [*3];
	endproperty
	a_wr_nosel: assert property (p_wr_nosel) else $error("unselected write acted");
endmodule : dfs_sequencer_chk
bind dfs_sequencer dfs_sequencer_chk #(.WIN_CYC(WIN_CYC)) u_chk (.CORE_CLK(CORE_CLK), .RST_B(RST_B),
	.ADDR(ADDR), .WDATA(WDATA), .WR_STROBE_B(WR_STROBE_B), .RD_STROBE_B(RD_STROBE_B),
	.PRIMARY_SECTOR_SELECT(PRIMARY_SECTOR_SELECT), .SECONDARY_SECTOR_SELECT(SECONDARY_SECTOR_SELECT),
	.RDATA(RDATA), .SECTOR_PROTECT(SECTOR_PROTECT), .READY_BUSY_OUTPUT(READY_BUSY_OUTPUT),
	.ERROR_FLAG_BIT(ERROR_FLAG_BIT));
`default_nettype wire

// ===== testbench/dfs_mcu_model.sv
// host bus model: plain read and write cycles
// assumes the caller passes a sector index 0 to 11, or 12 for a cycle with no select
`timescale 1ns/1ps
`default_nettype none
module dfs_mcu_model
	import dfs_pkg::*;
(
	// bus
	input  wire logic              clk,
	output logic [ADDR_W-1:0]      addr,
	output logic [7:0]             wdata,
	output logic                   wr_b,
	output logic                   rd_b,
	output logic [ALL_SECTORS-1:0] sel,
	input  wire logic [7:0]        rdata
);
	initial begin
		addr = 16'h0000;
		wdata = 8'h00;
		wr_b = 1'b1;
		rd_b = 1'b1;
		sel = 12'h000;
	end
	// released lines invert so stale values never look valid
	task automatic wr(input logic [15:0] a, input logic [7:0] d, input int s);
		@(negedge clk);
		addr = a;
		wdata = d;
		sel = 12'h001 << s;
		wr_b = 1'b0;
		repeat (2) @(negedge clk);
		wr_b = 1'b1;
		repeat (3) @(negedge clk);
		sel = 12'h000;
		addr = ~a;
		wdata = ~d;
	endtask : wr
	task automatic rd(input logic [15:0] a, input int s, output logic [7:0] d);
		@(negedge clk);
		addr = a;
		sel = 12'h001 << s;
		rd_b = 1'b0;
		repeat (2) @(negedge clk);
		d = rdata;
		rd_b = 1'b1;
		sel = 12'h000;
		addr = ~a;
	endtask : rd
endmodule : dfs_mcu_model
`default_nettype wire

// ===== testbench/tb_dfs_sequencer.sv
// testbench for the dual flash command sequencer
// assumes short gap and window parameters
`timescale 1ns/1ps
`default_nettype none
module tb_dfs_sequencer
	import dfs_pkg::*;
;
	localparam int GAP = 20;
	localparam int WIN = 20;
	localparam logic [7:0] ID = 8'hC3;  // arbitrary value
	logic        CORE_CLK;
	logic        RST_B;
	logic [15:0] addr;
	logic [7:0]  wdata;
	logic        wr_b;
	logic        rd_b;
	logic [11:0] sel;
	logic [11:0] prot;
	logic [7:0]  rdata;
	logic        ready;
	logic        err;
	int          num_errors;
	int          tests_run;
	dfs_mcu_model mcu (.clk(CORE_CLK), .addr(addr), .wdata(wdata), .wr_b(wr_b), .rd_b(rd_b),
		.sel(sel), .rdata(rdata));
	dfs_sequencer #(.GAP_CYC(GAP), .WIN_CYC(WIN), .IDENT_CODE(ID)) dut (.CORE_CLK(CORE_CLK),
		.RST_B(RST_B), .ADDR(addr), .WDATA(wdata), .WR_STROBE_B(wr_b), .RD_STROBE_B(rd_b),
		.PRIMARY_SECTOR_SELECT(sel[7:0]), .SECONDARY_SECTOR_SELECT(sel[11:8]), .RDATA(rdata),
		.SECTOR_PROTECT(prot), .READY_BUSY_OUTPUT(ready), .ERROR_FLAG_BIT(err));
	initial begin
		CORE_CLK = 1'b0;
		forever #20 CORE_CLK = ~CORE_CLK;
	end
	// ****************
	// helpers
	// ****************
	task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
		tests_run++;
		if (g !== e) begin
			num_errors++;
			$display("ERROR %0t byte %h exp %h", $time, g, e);
		end
	endtask : cmp8
	task automatic cmp1(input logic g, input logic e);
		tests_run++;
		if (g !== e) begin
			num_errors++;
			$display("ERROR %0t flag %b exp %b", $time, g, e);
		end
	endtask : cmp1
	task automatic rdc(input logic [15:0] a, input int s, input logic [7:0] e);
		logic [7:0] d;
		mcu.rd(a, s, d);
		cmp8(d, e);
	endtask : rdc
	// upper address nibble varies: it must be ignored
	task automatic unl(input logic [7:0] c);
		mcu.wr(16'hF555, CMD_UNLK1, 1);
		mcu.wr(16'h3AAA, CMD_UNLK2, 1);
		mcu.wr(16'h9555, c, 1);
	endtask : unl
	task automatic wrdy;
		for (int i = 0; i < 6000 && ready !== 1'b1; i++) @(negedge CORE_CLK);
		cmp1(ready, 1'b1);
	endtask : wrdy
	// ****************
	// scenarios
	// ****************
	task automatic t_erase;
		unl(CMD_ERASE);
		mcu.wr(16'h0AAA, CMD_UNLK1, 1);
		mcu.wr(16'h0AAA, CMD_UNLK2, 1);
		mcu.wr(16'h2100, CMD_SECTOR, 1);
		for (int i = 0; i < WIN + 10 && ready !== 1'b0; i++) @(negedge CORE_CLK);
		cmp1(ready, 1'b0);
		wrdy();
		rdc(16'h2100, 1, ERASED_BYTE);
		$display("done erase");
	endtask : t_erase
	task automatic t_prog;
		unl(CMD_PROG);
		mcu.wr(16'h2100, 8'h3C, 1);
		cmp1(ready, 1'b0);
		wrdy();
		rdc(16'h2100, 1, 8'h3C);
		unl(CMD_PROG);
		mcu.wr(16'h2100, 8'h0F, 1);
		wrdy();
		rdc(16'h2100, 1, 8'h0C);
		$display("done program");
	endtask : t_prog
	task automatic t_ident;
		unl(CMD_IDENT);
		rdc(16'h0001, 1, ID);
		rdc(16'h0002, 1, DATA_UNPROT);
		prot[5] = 1'b1;
		rdc(16'hA002, 5, DATA_PROT);
		mcu.wr(16'h0000, CMD_RESET, 1);
		rdc(16'h2100, 1, 8'h0C);
		$display("done ident");
	endtask : t_ident
	task automatic t_abort;
		mcu.wr(16'h2100, 8'h00, 1);
		mcu.wr(16'h0555, CMD_UNLK1, 1);
		mcu.wr(16'h0AAA, 8'h12, 1);
		mcu.wr(16'h0555, CMD_PROG, 1);
		mcu.wr(16'h2100, 8'h00, 1);
		cmp1(ready, 1'b1);
		mcu.wr(16'h0555, CMD_UNLK1, 1);
		mcu.wr(16'h0AAA, CMD_UNLK2, 1);
		repeat (GAP + 10) @(negedge CORE_CLK);
		mcu.wr(16'h0555, CMD_PROG, 1);
		mcu.wr(16'h2100, 8'h00, 1);
		cmp1(ready, 1'b1);
		mcu.wr(16'h0555, CMD_UNLK1, 12);
		mcu.wr(16'h0AAA, CMD_UNLK2, 12);
		mcu.wr(16'h0555, CMD_PROG, 12);
		mcu.wr(16'h2100, 8'h00, 12);
		cmp1(ready, 1'b1);
		rdc(16'h2100, 1, 8'h0C);
		$display("done abort");
	endtask : t_abort
	task automatic t_protect;
		prot[1] = 1'b1;
		unl(CMD_PROG);
		mcu.wr(16'h2100, 8'h00, 1);
		cmp1(ready, 1'b1);
		rdc(16'h2100, 1, 8'h0C);
		prot[1] = 1'b0;
		$display("done protect");
	endtask : t_protect
	task automatic t_bypass;
		unl(CMD_BYPASS);
		mcu.wr(16'h0000, CMD_PROG, 1);
		mcu.wr(16'h2100, 8'h04, 1);
		cmp1(ready, 1'b0);
		wrdy();
		mcu.wr(16'h0000, CMD_IDENT, 1);
		mcu.wr(16'h0000, CMD_BYP_END, 1);
		mcu.wr(16'h0000, CMD_PROG, 1);
		mcu.wr(16'h2100, 8'h00, 1);
		cmp1(ready, 1'b1);
		rdc(16'h2100, 1, 8'h04);
		$display("done bypass");
	endtask : t_bypass
	task automatic t_bulk;
		prot = 12'hFF7;
		unl(CMD_ERASE);
		mcu.wr(16'h0AAA, CMD_UNLK1, 1);
		mcu.wr(16'h0AAA, CMD_UNLK2, 1);
		mcu.wr(16'h0555, CMD_BULK, 1);
		cmp1(ready, 1'b0);
		mcu.wr(16'h0000, CMD_SUSPEND, 1);
		wrdy();
		rdc(16'h6100, 3, ERASED_BYTE);
		rdc(16'h2100, 1, 8'h04);
		prot = 12'h000;
		$display("done bulk");
	endtask : t_bulk
	task automatic t_suspend;
		unl(CMD_ERASE);
		mcu.wr(16'h0AAA, CMD_UNLK1, 1);
		mcu.wr(16'h0AAA, CMD_UNLK2, 1);
		mcu.wr(16'h4100, CMD_SECTOR, 2);
		for (int i = 0; i < WIN + 10 && ready !== 1'b0; i++) @(negedge CORE_CLK);
		cmp1(ready, 1'b0);
		mcu.wr(16'h0000, CMD_SUSPEND, 1);
		rdc(16'h2100, 1, 8'h04);
		repeat (5000) @(negedge CORE_CLK);
		cmp1(ready, 1'b0);
		mcu.wr(16'h0000, CMD_SECTOR, 1);
		wrdy();
		rdc(16'h4100, 2, ERASED_BYTE);
		$display("done suspend");
	endtask : t_suspend
	task automatic results;
		$display("tests %0d errors %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : results
	initial begin
		num_errors = 0;
		tests_run = 0;
		RST_B = 1'b0;
		prot = 12'h000;
		repeat (5) @(negedge CORE_CLK);
		RST_B = 1'b1;
		repeat (2) @(negedge CORE_CLK);
		cmp1(ready, 1'b1);
		cmp1(err, 1'b0);
		$display("done reset");
		t_erase();
		t_prog();
		t_ident();
		t_abort();
		t_protect();
		t_bypass();
		t_bulk();
		t_suspend();
		results();
	end
	initial begin
		#(40 * 60000);
		num_errors++;
		results();
	end
endmodule : tb_dfs_sequencer
`default_nettype wire
